/* File: design/spims_top.sv */
// byte wide serial peripheral port, master or slave, mode 0 timing
`timescale 1ns/1ps
module spims_top (
   input wire logic REF_CLK, // peripheral clock, 50 MHz
   input wire logic RESET, // async reset, high
   input wire logic ENABLE, // port enable
   input wire logic CTRL_WR, // strobe: load role bit
   input wire logic MASTER_IN, // role bit value, 1 master
   input wire logic [1:0] CLOCK_DIVIDER_SELECT, // master rate select
   input wire logic DOUBLE_SPEED_SELECT, // halves master divider
   input wire logic BIT_ORDER_SELECT, // 1 lsb first
   input wire logic BUFFERED_MODE_ENABLE, // buffered mode
   input wire logic SELECT_PIN_DISABLE, // master ignores select pin
   input wire logic DEBUG_HALT, // processor halted by debugger
   input wire logic DATA_WR, // strobe: data register write
   input wire logic [7:0] DATA_WDATA, // data to send
   input wire logic DATA_RD, // strobe: data register read
   input wire logic DONE_CLR, // strobe: clear done flag
   input wire logic CLASH_CLR, // strobe: clear clash flag
   input wire logic MOSI_DIR, // port direction, 1 output
   input wire logic MISO_DIR, // port direction, 1 output
   input wire logic SCK_DIR, // port direction, 1 output
   input wire logic SS_DIR, // port direction, 1 output
   input wire logic MOSI_I, // mosi pin level
   input wire logic MISO_I, // miso pin level
   input wire logic SCK_I, // sck pin level
   input wire logic SS_N_I, // select pin level, low active
   output logic MOSI_O, // mosi drive value
   output logic MOSI_OE, // mosi drive enable
   output logic MISO_O, // miso drive value
   output logic MISO_OE, // miso drive enable
   output logic SCK_O, // sck drive value
   output logic SCK_OE, // sck drive enable
   output logic [7:0] DATA_RDATA, // data register read value
   output logic DONE_FLAG, // transfer done, sticky
   output logic WRITE_CLASH_FLAG, // write collision, sticky
   output logic MASTER_STATE, // role bit
   output logic TX_BUF_FULL // transmit buffer holds a byte
);
   localparam int W = spims_pkg::DATA_W;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic ss_s1, ss_s, sck_s1, sck_s, mosi_s1, mosi_s, miso_s1, miso_s, sck_d1;

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         {ss_s1, ss_s} <= 2'h3;
         {sck_s1, sck_s, sck_d1} <= 3'h0;
         {mosi_s1, mosi_s, miso_s1, miso_s} <= 4'h0;
      end else begin
         {ss_s1, ss_s} <= {SS_N_I, ss_s1};
         {sck_s1, sck_s, sck_d1} <= {SCK_I, sck_s1, sck_s};
         {mosi_s1, mosi_s, miso_s1, miso_s} <= {MOSI_I, mosi_s1, MISO_I, miso_s1};
      end
   end

   // ----------------------------------------------------------------
   // state and decode
   // ----------------------------------------------------------------
   spims_pkg::spims_state_t st_q, st_d;
   logic [W-1:0] sr_q, sr_d, txb_q, txb_d, rx1_q, rx1_d, rx2_q, rx2_d, samp_rd;
   logic [2:0] bit_q, bit_d;
   logic [1:0] rxc_q, rxc_d;
   logic sck_q, sck_d, txf_q, txf_d, master_q, samp_q, done_q, clash_q, tick;

   wire logic run_ok = ENABLE & ~DEBUG_HALT;
   wire logic is_master = ENABLE & master_q;
   wire logic in_shift = (st_q == spims_pkg::SPIMS_SHIFT);
   wire logic in_idle = (st_q == spims_pkg::SPIMS_IDLE);
   wire logic in_done = (st_q == spims_pkg::SPIMS_DONE);
   wire logic buf_mode = BUFFERED_MODE_ENABLE;
   wire logic takeover = is_master & ~SELECT_PIN_DISABLE & ~SS_DIR & ~ss_s
                         & ~DEBUG_HALT;
   wire logic slave_sel = ENABLE & ~master_q & ~ss_s;
   wire logic slave_abort = ~ENABLE | (~master_q & ss_s);
   wire logic sck_rise = sck_s & ~sck_d1;
   wire logic sck_fall = ~sck_s & sck_d1;
   wire logic gen_run = is_master & in_shift & ~DEBUG_HALT;
   wire logic m_rise = tick & ~sck_q;
   wire logic m_fall = tick & sck_q;
   wire logic shift_now = in_shift & (master_q ? m_fall : (slave_sel & sck_fall));
   wire logic last_bit = (bit_q == spims_pkg::BIT_LAST);
   wire logic in_bit = master_q ? miso_s : samp_q;
   wire logic out_bit = BIT_ORDER_SELECT ? sr_q[0] : sr_q[W-1];
   wire logic [W-1:0] shifted = BIT_ORDER_SELECT ? {in_bit, sr_q[W-1:1]}
                                                 : {sr_q[W-2:0], in_bit};
   wire logic busy = in_shift & (master_q | (bit_q != spims_pkg::BIT_FIRST));
   wire logic wr = DATA_WR & ENABLE;
   wire logic idle_pop = in_idle & buf_mode & txf_q & run_ok;
   wire logic direct_ok = ~busy & ~in_done & ~txf_q;
   wire logic rx_push = in_done & ~DEBUG_HALT;
   wire logic rx_pop = DATA_RD & buf_mode & (rxc_q != spims_pkg::RX_EMPTY);
   wire logic [6:0] half_w = spims_pkg::spims_half(CLOCK_DIVIDER_SELECT,
                                                   DOUBLE_SPEED_SELECT);

   // serial clock from the peripheral clock only
   spims_sck_gen #(.CNT_W(spims_pkg::HALF_W)) u_gen (
      .clk(REF_CLK),
      .rst(RESET),
      .run(gen_run),
      .half(half_w),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // transfer sequencing
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      sr_d = sr_q;
      bit_d = bit_q;
      sck_d = sck_q;
      txb_d = txb_q;
      txf_d = txf_q;
      if (!DEBUG_HALT) begin
         unique case (st_q)
            spims_pkg::SPIMS_IDLE: begin
               bit_d = spims_pkg::BIT_FIRST;
               if (idle_pop) begin
                  sr_d = txb_q;
                  txf_d = 1'b0;
               end
               if (slave_sel || (idle_pop && is_master)) begin
                  st_d = spims_pkg::SPIMS_SHIFT;
               end
            end
            spims_pkg::SPIMS_SHIFT: begin
               if (m_rise) begin
                  sck_d = 1'b1;
               end
               if (shift_now) begin
                  sr_d = shifted;
                  bit_d = bit_q + 3'h1;
                  sck_d = 1'b0;
                  if (last_bit) begin
                     st_d = spims_pkg::SPIMS_DONE;
                  end
               end
               if (slave_abort) begin
                  st_d = spims_pkg::SPIMS_IDLE;
                  bit_d = spims_pkg::BIT_FIRST;
                  sck_d = 1'b0;
               end
            end
            default: begin
               st_d = spims_pkg::SPIMS_IDLE;
               bit_d = spims_pkg::BIT_FIRST;
            end
         endcase
      end
      // the clash write still lands in the shifter: the byte on the wire is garbled
      if (wr && !buf_mode) begin
         sr_d = DATA_WDATA;
         if (is_master && !busy) begin
            st_d = spims_pkg::SPIMS_SHIFT;
            bit_d = spims_pkg::BIT_FIRST;
            sck_d = 1'b0;
         end
      end else if (wr && direct_ok) begin
         sr_d = DATA_WDATA;
         if (is_master) begin
            st_d = spims_pkg::SPIMS_SHIFT;
            bit_d = spims_pkg::BIT_FIRST;
            sck_d = 1'b0;
         end
      end else if (wr && (!txf_q || idle_pop)) begin
         txb_d = DATA_WDATA;
         txf_d = 1'b1;
      end
      if (takeover) begin
         st_d = spims_pkg::SPIMS_IDLE;
         bit_d = spims_pkg::BIT_FIRST;
         sck_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // receive buffers
   // ----------------------------------------------------------------
   always_comb begin
      rx1_d = rx1_q;
      rx2_d = rx2_q;
      rxc_d = rxc_q;
      if (!buf_mode) begin
         if (rx_push) begin
            rx1_d = sr_q;
         end
      end else if (rx_push) begin
         // a third byte overwrites the newest entry: reader must keep up
         unique case (rxc_q)
            spims_pkg::RX_EMPTY: begin
               rx2_d = sr_q;
               rxc_d = spims_pkg::RX_ONE;
            end
            spims_pkg::RX_ONE: begin
               if (rx_pop) begin
                  rx2_d = sr_q;
               end else begin
                  rx1_d = sr_q;
                  rxc_d = spims_pkg::RX_TWO;
               end
            end
            default: begin
               if (rx_pop) begin
                  rx2_d = rx1_q;
               end
               rx1_d = sr_q;
               rxc_d = spims_pkg::RX_TWO;
            end
         endcase
      end else if (rx_pop) begin
         rx2_d = rx1_q;
         rxc_d = rxc_q - 2'h1;
      end
   end

   assign samp_rd = buf_mode ? rx2_d : rx1_d;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= spims_pkg::SPIMS_IDLE;
         {sr_q, txb_q, rx1_q, rx2_q} <= {4{spims_pkg::DATA_RST}};
         bit_q <= spims_pkg::BIT_FIRST;
         rxc_q <= spims_pkg::RX_EMPTY;
         {sck_q, txf_q, samp_q} <= 3'h0;
      end else begin
         st_q <= st_d;
         {sr_q, txb_q, rx1_q, rx2_q} <= {sr_d, txb_d, rx1_d, rx2_d};
         bit_q <= bit_d;
         rxc_q <= rxc_d;
         {sck_q, txf_q} <= {sck_d, txf_d};
         if (sck_rise && slave_sel && !DEBUG_HALT) begin
            samp_q <= mosi_s;
         end
      end
   end

   // role bit and sticky flags; a hardware set wins over a clear
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         {master_q, done_q, clash_q} <= 3'h0;
      end else begin
         master_q <= takeover ? 1'b0 : (CTRL_WR ? MASTER_IN : master_q);
         done_q <= rx_push | takeover | (done_q & ~DONE_CLR);
         clash_q <= (wr & ~buf_mode & busy) | (clash_q & ~CLASH_CLR);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         {MOSI_O, MOSI_OE, MISO_O, MISO_OE, SCK_O, SCK_OE} <= 6'h00;
         DATA_RDATA <= spims_pkg::DATA_RST;
         {DONE_FLAG, WRITE_CLASH_FLAG, MASTER_STATE, TX_BUF_FULL} <= 4'h0;
      end else begin
         MOSI_O <= out_bit;
         MOSI_OE <= is_master & MOSI_DIR;
         MISO_O <= out_bit;
         MISO_OE <= ENABLE & ~master_q & MISO_DIR & ~ss_s;
         SCK_O <= sck_q;
         SCK_OE <= is_master & SCK_DIR;
         DATA_RDATA <= samp_rd;
         {DONE_FLAG, WRITE_CLASH_FLAG} <= {done_q, clash_q};
         {MASTER_STATE, TX_BUF_FULL} <= {master_q, txf_q};
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [3:0] nshift_q;
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         nshift_q <= 4'h0;
      end else if (in_idle || in_done) begin
         nshift_q <= 4'h0;
      end else if (shift_now && !DEBUG_HALT) begin
         nshift_q <= nshift_q + 4'h1;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   chk_master_miso_in: assert property ($past(is_master) |-> !MISO_OE)
      else $error("miso driven in master mode");
   chk_slave_pins_in: assert property ($past(ENABLE & ~master_q) |-> !MOSI_OE && !SCK_OE)
      else $error("slave drives mosi or sck");
   chk_miso_tristate: assert property ($past(ss_s) |-> !MISO_OE)
      else $error("miso driven while deselected");
   chk_eight_bits: assert property (in_done && master_q |-> nshift_q == spims_pkg::SHIFTS_PER_BYTE)
      else $error("master byte not eight shifts");
   chk_done_flag: assert property (rx_push |=> done_q ##1 DONE_FLAG)
      else $error("done flag not raised");
   chk_clash_flag: assert property (wr && !buf_mode && busy |=> clash_q)
      else $error("clash flag not raised");
   chk_takeover_drop: assert property (takeover |=> !master_q && done_q && in_idle)
      else $error("select takeover not handled");
   chk_halt_freeze: assert property (DEBUG_HALT && in_shift && !DATA_WR && !takeover
                                     |=> $stable(sr_q) && $stable(bit_q))
      else $error("shifter moved while halted");
   chk_lsb_order: assert property (shift_now && !DEBUG_HALT && BIT_ORDER_SELECT
                                   && !wr |=> sr_q[7] == $past(in_bit))
      else $error("lsb first shift wrong");
   chk_fast_rate: assert property (gen_run && $past(gen_run) && half_w == 7'h01
                                   |-> tick)
      else $error("double speed rate not half clock");

   cov_master_byte: cover property (in_done && master_q);
   cov_slave_byte: cover property (in_done && !master_q);
   cov_takeover: cover property (takeover);
   cov_buffered_chain: cover property (idle_pop && is_master);
endmodule : spims_top

/* File: pkg/spims_pkg.sv */
// constants, state encoding and rate table for the serial port
package spims_pkg;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int HALF_W = 7;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] SHIFTS_PER_BYTE = 4'h8;

   // ----------------------------------------------------------------
   // receive fifo fill levels (buffered mode)
   // ----------------------------------------------------------------
   localparam logic [1:0] RX_EMPTY = 2'h0;
   localparam logic [1:0] RX_ONE = 2'h1;
   localparam logic [1:0] RX_TWO = 2'h2;

   // ----------------------------------------------------------------
   // serial clock half periods in peripheral clock cycles
   // ----------------------------------------------------------------
   localparam logic [HALF_W-1:0] HALF_DIV4 = 7'h02;
   localparam logic [HALF_W-1:0] HALF_DIV16 = 7'h08;
   localparam logic [HALF_W-1:0] HALF_DIV64 = 7'h20;
   localparam logic [HALF_W-1:0] HALF_DIV128 = 7'h40;
   // least sck phase an outside master must keep, in clock cycles
   localparam int SCK_MIN_PHASE_CYC = 2;

   typedef enum logic [1:0] {
      SPIMS_IDLE  = 2'b00,
      SPIMS_SHIFT = 2'b01,
      SPIMS_DONE  = 2'b11
   } spims_state_t;

   // double speed halves every divider, giving seven distinct rates
   function automatic logic [HALF_W-1:0] spims_half(input logic [1:0] sel, input logic dbl);
      logic [HALF_W-1:0] h;
      unique case (sel)
         2'h0: h = HALF_DIV4;
         2'h1: h = HALF_DIV16;
         2'h2: h = HALF_DIV64;
         default: h = HALF_DIV128;
      endcase
      return dbl ? (h >> 1) : h;
   endfunction : spims_half

endpackage : spims_pkg

/* File: design/spims_sck_gen.sv */
// half period tick generator for the master serial clock
`timescale 1ns/1ps
module spims_sck_gen #(
   parameter int CNT_W = spims_pkg::HALF_W
) (
   input wire logic clk, // peripheral clock
   input wire logic rst, // async reset, high
   input wire logic run, // count while high
   input wire logic [CNT_W-1:0] half, // half period in cycles, at least one
   output logic tick // one cycle per half period
);
   logic [CNT_W-1:0] cnt_q;
   wire logic at_end = (cnt_q == CNT_W'(half - 1'b1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (at_end) begin
         cnt_q <= '0;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : spims_sck_gen

/* File: dv/spims_slave_model.sv */
// behavioural outside slave device, mode 0, one shared shift register
`timescale 1ns/1ps
module spims_slave_model (
   input wire logic sck, // serial clock from master
   input wire logic mosi, // data from master
   input wire logic sel_n, // select, low active
   input wire logic lsb_first, // bit order
   input wire logic [7:0] tx_byte, // byte loaded on select
   output logic miso, // data to master
   output logic [7:0] rx_byte // last whole byte received
);
   logic [7:0] sh;
   logic bit_in;
   int cnt;
   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
      sh = 8'h00;
      bit_in = 1'b0;
      cnt = 0;
   end
   always @(negedge sel_n) begin
      sh = tx_byte;
      cnt = 0;
      miso = lsb_first ? sh[0] : sh[7];
   end
   // released line has no pull, so show the inverse rather than a stale bit
   always @(posedge sel_n) miso = ~miso;
   always @(posedge sck) if (!sel_n) bit_in = mosi;
   always @(negedge sck) begin
      if (!sel_n) begin
         sh = lsb_first ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
         cnt++;
         if (cnt % 8 == 0) rx_byte = sh;
         miso = lsb_first ? sh[0] : sh[7];
      end
   end
endmodule : spims_slave_model

/* File: dv/spims_top_bench.sv */
// self-checking bench for the serial port with an outside slave model
`timescale 1ns/1ps
module spims_top_bench;
   logic REF_CLK = 1'b0, RESET = 1'b1, ENABLE = 1'b0, CTRL_WR = 1'b0, MASTER_IN = 1'b0;
   logic [1:0] CLOCK_DIVIDER_SELECT = 2'h0;
   logic DOUBLE_SPEED_SELECT = 1'b0, BIT_ORDER_SELECT = 1'b0, BUFFERED_MODE_ENABLE = 1'b0;
   logic SELECT_PIN_DISABLE = 1'b0, DEBUG_HALT = 1'b0, DATA_WR = 1'b0, DATA_RD = 1'b0;
   logic [7:0] DATA_WDATA = 8'h00;
   logic DONE_CLR = 1'b0, CLASH_CLR = 1'b0, MOSI_DIR = 1'b1, MISO_DIR = 1'b1, SCK_DIR = 1'b1;
   logic SS_DIR = 1'b0, SS_N_I = 1'b1, m_sck = 1'b0, m_mosi = 1'b0, s_sel_n = 1'b1;
   logic MOSI_O, MOSI_OE, MISO_O, MISO_OE, SCK_O, SCK_OE, DONE_FLAG, WRITE_CLASH_FLAG;
   logic MASTER_STATE, TX_BUF_FULL, s_miso, sck_q = 1'b0;
   logic [7:0] DATA_RDATA, s_tx = 8'h00, s_rx, b1, b2, got;
   logic [15:0] rnd = 16'h6A17;
   wire sck_w = SCK_OE ? SCK_O : m_sck;
   wire mosi_w = MOSI_OE ? MOSI_O : m_mosi;
   wire miso_w = MISO_OE ? MISO_O : s_miso;
   int err_total = 0, samples_checked = 0, hi_cnt = 0, rise_cnt = 0, h0, r0, hf, i, n;

   always #10 REF_CLK = ~REF_CLK;
   // counted on the falling edge so posedge reads never race the update
   always @(negedge REF_CLK) begin
      if (SCK_O === 1'b1) hi_cnt++;
      if (SCK_O === 1'b1 && sck_q === 1'b0) rise_cnt++;
      sck_q = SCK_O;
   end

   spims_top dut (.REF_CLK(REF_CLK), .RESET(RESET), .ENABLE(ENABLE), .CTRL_WR(CTRL_WR),
      .MASTER_IN(MASTER_IN), .CLOCK_DIVIDER_SELECT(CLOCK_DIVIDER_SELECT),
      .DOUBLE_SPEED_SELECT(DOUBLE_SPEED_SELECT), .BIT_ORDER_SELECT(BIT_ORDER_SELECT),
      .BUFFERED_MODE_ENABLE(BUFFERED_MODE_ENABLE), .SELECT_PIN_DISABLE(SELECT_PIN_DISABLE),
      .DEBUG_HALT(DEBUG_HALT), .DATA_WR(DATA_WR), .DATA_WDATA(DATA_WDATA), .DATA_RD(DATA_RD),
      .DONE_CLR(DONE_CLR), .CLASH_CLR(CLASH_CLR), .MOSI_DIR(MOSI_DIR), .MISO_DIR(MISO_DIR),
      .SCK_DIR(SCK_DIR), .SS_DIR(SS_DIR), .MOSI_I(mosi_w), .MISO_I(miso_w), .SCK_I(sck_w),
      .SS_N_I(SS_N_I), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_O(MISO_O), .MISO_OE(MISO_OE),
      .SCK_O(SCK_O), .SCK_OE(SCK_OE), .DATA_RDATA(DATA_RDATA), .DONE_FLAG(DONE_FLAG),
      .WRITE_CLASH_FLAG(WRITE_CLASH_FLAG), .MASTER_STATE(MASTER_STATE),
      .TX_BUF_FULL(TX_BUF_FULL));

   spims_slave_model partner (.sck(sck_w), .mosi(mosi_w), .sel_n(s_sel_n),
      .lsb_first(BIT_ORDER_SELECT), .tx_byte(s_tx), .miso(s_miso), .rx_byte(s_rx));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   function automatic int half_exp(input int sel, input logic dbl);
      int h;
      h = (sel == 0) ? 2 : (sel == 1) ? 8 : (sel == 2) ? 32 : 64;
      return dbl ? h / 2 : h;
   endfunction : half_exp
   task automatic tick(input int c);
      repeat (c) @(posedge REF_CLK);
   endtask : tick
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] d);
      DATA_WDATA <= d;
      DATA_WR <= 1'b1;
      tick(1);
      DATA_WR <= 1'b0;
      tick(1);
   endtask : wr
   task automatic wait_done;
      n = 0;
      while (DONE_FLAG !== 1'b1 && n < 5000) begin
         tick(1);
         n++;
      end
      chk(16'(n < 5000), 16'h0001);
   endtask : wait_done
   task automatic clr_done;
      DONE_CLR <= 1'b1;
      tick(1);
      DONE_CLR <= 1'b0;
      tick(2);
   endtask : clr_done
   task automatic test_done;
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   initial begin
      #(60000 * 20);
      err_total++;
      test_done();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      tick(8);
      RESET <= 1'b0;
      tick(2);
      chk({MOSI_OE, MISO_OE, SCK_OE, DONE_FLAG, WRITE_CLASH_FLAG, MASTER_STATE}, 16'h0000);
      MASTER_IN <= 1'b1;
      CTRL_WR <= 1'b1;
      tick(1);
      CTRL_WR <= 1'b0;
      ENABLE <= 1'b1;
      tick(3);
      chk({MASTER_STATE, MOSI_OE, SCK_OE, MISO_OE}, 16'h000E);
      // seven rates, random bytes and order
      for (int r = 0; r < 7; r++) begin
         rnd = lfsr(rnd);
         b1 = rnd[7:0];
         s_tx = rnd[15:8];
         CLOCK_DIVIDER_SELECT <= (r == 6) ? 2'h3 : 2'(r / 2);
         DOUBLE_SPEED_SELECT <= (r != 6) && (r % 2 == 0);
         BIT_ORDER_SELECT <= rnd[3];
         hf = half_exp((r == 6) ? 3 : r / 2, (r != 6) && (r % 2 == 0));
         s_sel_n <= 1'b0;
         tick(2);
         h0 = hi_cnt;
         r0 = rise_cnt;
         wr(b1);
         wait_done();
         tick(3);
         chk(16'(hi_cnt - h0), 16'(8 * hf));
         chk(16'(rise_cnt - r0), 16'h0008);
         chk(s_rx, b1);
         // master reads the synced miso, too late at the fastest rate
         if (hf > 1) begin
            chk(DATA_RDATA, s_tx);
         end
         s_sel_n <= 1'b1;
         clr_done();
      end
      // write during a transfer
      CLOCK_DIVIDER_SELECT <= 2'h1;
      DOUBLE_SPEED_SELECT <= 1'b0;
      wr(8'h5A);
      tick(10);
      wr(8'hA5);
      wait_done();
      tick(3);
      chk(WRITE_CLASH_FLAG, 16'h0001);
      CLASH_CLR <= 1'b1;
      tick(1);
      CLASH_CLR <= 1'b0;
      tick(3);
      chk(WRITE_CLASH_FLAG, 16'h0000);
      clr_done();
      // debugger halt freezes the serial clock
      r0 = rise_cnt;
      wr(8'h3C);
      tick(20);
      DEBUG_HALT <= 1'b1;
      tick(4);
      h0 = rise_cnt;
      tick(100);
      chk(16'(rise_cnt - h0), 16'h0000);
      chk(DONE_FLAG, 16'h0000);
      DEBUG_HALT <= 1'b0;
      wait_done();
      tick(3);
      chk(16'(rise_cnt - r0), 16'h0008);
      clr_done();
      // buffered: two bytes taken, third refused while buffer full
      BUFFERED_MODE_ENABLE <= 1'b1;
      rnd = lfsr(rnd);
      b1 = rnd[7:0];
      b2 = rnd[15:8];
      s_tx = 8'h96;
      s_sel_n <= 1'b0;
      tick(2);
      r0 = rise_cnt;
      DATA_WDATA <= b1;
      DATA_WR <= 1'b1;
      tick(1);
      DATA_WDATA <= b2;
      tick(1);
      DATA_WDATA <= 8'hFF;
      tick(1);
      DATA_WR <= 1'b0;
      tick(2);
      chk(TX_BUF_FULL, 16'h0001);
      n = 0;
      while (rise_cnt - r0 < 16 && n < 3000) begin
         tick(1);
         n++;
      end
      wait_done();
      tick(300);
      chk(16'(rise_cnt - r0), 16'h0010);
      chk(DATA_RDATA, 8'h96);
      DATA_RD <= 1'b1;
      tick(1);
      DATA_RD <= 1'b0;
      tick(3);
      chk(DATA_RDATA, b1);
      chk(s_rx, b2);
      s_sel_n <= 1'b1;
      BUFFERED_MODE_ENABLE <= 1'b0;
      clr_done();
      // select pin: ignored when disabled, takeover otherwise
      SELECT_PIN_DISABLE <= 1'b1;
      SS_N_I <= 1'b0;
      tick(8);
      chk(MASTER_STATE, 16'h0001);
      SELECT_PIN_DISABLE <= 1'b0;
      tick(8);
      chk({MASTER_STATE, DONE_FLAG}, 16'h0001);
      SS_N_I <= 1'b1;
      clr_done();
      tick(1);
      chk({MOSI_OE, SCK_OE, MISO_OE}, 16'h0000);
      // slave transfer, bench acts as outside master, msb first
      BIT_ORDER_SELECT <= 1'b0;
      rnd = lfsr(rnd);
      b1 = rnd[7:0];
      b2 = rnd[15:8];
      wr(b1);
      SS_N_I <= 1'b0;
      tick(6);
      chk(MISO_OE, 16'h0001);
      for (i = 7; i >= 0; i--) begin
         m_mosi <= b2[i];
         tick(4);
         m_sck <= 1'b1;
         tick(4);
         // late in the high phase: miso settled after the synced shift
         got[i] = MISO_O;
         m_sck <= 1'b0;
      end
      wait_done();
      tick(3);
      chk(got, b1);
      chk(DATA_RDATA, b2);
      SS_N_I <= 1'b1;
      tick(6);
      chk(MISO_OE, 16'h0000);
      test_done();
   end
endmodule : spims_top_bench
